// ===== hdl/ffh_history.sv
// Eight-deep error history stack, newest record in slot 0
module ffh_history
    import ffh_pkg::*;
(
    input wire logic hclk, // System clock
    input wire logic hresetn, // Asynchronous reset, active low
    input wire logic push, // Insert a record this cycle
    input wire logic [31:0] push_rec, // Record to insert
    input wire logic clear, // Empty the stack
    input wire logic [2:0] rd_sel, // Slot to read, 0 is newest
    output logic [31:0] rd_rec // Selected record
);

    ffh_hist_s st_r; // R5
    ffh_hist_s st_nxt;

    // ****************************************
    // Shift and insert
    // ****************************************
    // A clear empties every slot first, so a record pushed in the same
    // cycle still lands as the single newest entry
    always_comb begin
        st_nxt = st_r;
        if (clear) begin
            for (int i = 0; i < `FFH_DEPTH; i++) begin
                st_nxt.slot[i] = `FFH_SLOT_RESET;
            end
        end
        if (push) begin
            // Older slots move back by one, the last one falls off
            for (int i = `FFH_DEPTH - 1; i > 0; i--) begin
                st_nxt.slot[i] = clear ? `FFH_SLOT_RESET : st_r.slot[i-1]; // R7 R8
            end
            st_nxt.slot[0] = push_rec; // R6
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_rec = st_r.slot[rd_sel];

endmodule

// ===== hdl/ffh_pkg.sv
// Types shared by the fault flag and error history modules
package ffh_pkg;
`include "ffh_regs.svh"

    // Kind of bus access held over into the data phase
    typedef enum logic [1:0] {
        FFH_ACC_NONE = 2'b00,
        FFH_ACC_READ = 2'b01,
        FFH_ACC_WRITE = 2'b10
    } ffh_acc_e;

    // State of the history stack
    typedef struct packed {
        logic [`FFH_DEPTH-1:0][31:0] slot;
    } ffh_hist_s;

    // State of the register front end
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] count;
        logic [`FFH_IRQ_W-1:0] irq_stat;
        logic [`FFH_IRQ_W-1:0] irq_mask;
        ffh_acc_e phase;
        logic [31:0] wr_addr;
        logic [31:0] rdata;
    } ffh_top_s;

endpackage

// ===== hdl/ffh_regs.svh
// Offsets, field positions, reset values and codes of the fault flag block
`ifndef FFH_REGS_SVH
`define FFH_REGS_SVH

// ****************************************
// Register indices and byte addresses
// ****************************************
`define FFH_IDX_FLAGS 16'h1001
`define FFH_IDX_COUNT 16'h1003
`define FFH_ADDR_FLAGS ({16'h0000, `FFH_IDX_FLAGS} << 2)
`define FFH_ADDR_COUNT ({16'h0000, `FFH_IDX_COUNT} << 2)
`define FFH_ADDR_SLOT1 32'h0000_4010
`define FFH_ADDR_SLOT8 32'h0000_402c
`define FFH_ADDR_IRQ_STAT 32'h0000_4040
`define FFH_ADDR_IRQ_MASK 32'h0000_4044

// ****************************************
// Fault flag fields
// ****************************************
`define FFH_NUM_FLAGS 8
`define FFH_BIT_OVERALL 0
`define FFH_BIT_AMPERAGE 1
`define FFH_BIT_SUPPLY 2
`define FFH_BIT_TEMPERATURE 3
`define FFH_BIT_LINK 4
`define FFH_BIT_DEVICE_CLASS 5
`define FFH_BIT_SPARE 6
`define FFH_BIT_VENDOR_ROT 7
`define FFH_FLAGS_RESET 8'h00

// ****************************************
// History record and stack
// ****************************************
`define FFH_DEPTH 8
`define FFH_REC_NUM_LSB 24
`define FFH_REC_CLASS_LSB 16
`define FFH_REC_CODE_LSB 0
`define FFH_COUNT_RESET 8'h00
`define FFH_COUNT_MAX 8'hff
`define FFH_SLOT_RESET 32'h0000_0000
`define FFH_ABORT_NO_DATA 32'h0800_0024

// ****************************************
// Interrupt status bits
// ****************************************
`define FFH_IRQ_W 3
`define FFH_IRQ_NEW_REC 0
`define FFH_IRQ_REFUSED 1
`define FFH_IRQ_FLAG_CHG 2

`endif

// ===== hdl/ffh_top.sv
// Fault flag register and error history with an AHB-Lite register slave
//
// Contract
// R1 - Flag follows its cause, clears when gone
// R2 - Eight flag bits, bit six reads zero
// R3 - Bit seven flags wrong rotation direction
// R4 - Bit five reports device profile errors
// R5 - History holds up to eight 32-bit records
// R6 - New record goes into newest slot
// R7 - Older records shift back one place first
// R8 - Record in the oldest slot is dropped
// R9 - Position zero reports errors recorded so far
// R10 - Empty history read refused with abort code
// R11 - Writing zero to count restarts counting
// R12 - Record is number, class, sixteen-bit code
// R13 - Class byte equals flags at recording time
// R14 - Several flags may stand independently together
//
// Implementation choice: the AHB-Lite interface to the registers.
module ffh_top
    import ffh_pkg::*;
(
    input wire logic hclk, // System clock, 10 MHz
    input wire logic hresetn, // Asynchronous reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // High for write
    input wire logic [2:0] hsize, // Transfer size, word only
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready in
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready out
    output logic hresp, // Response, always OKAY
    input wire logic [7:0] fault_cond, // Live error conditions per class
    input wire logic rec_valid, // Pulse: record a new error
    input wire logic [7:0] rec_number, // Error number of the new record
    input wire logic [15:0] rec_code, // Error code of the new record
    output logic [7:0] fault_flags, // Current fault flag register
    output logic [7:0] error_history_count, // Errors recorded so far
    output logic history_empty, // High while no record is held
    output logic irq // Level interrupt
);

    // ****************************************
    // State and local signals
    // ****************************************
    ffh_top_s st_r;
    ffh_top_s st_nxt;

    logic [7:0] flags_live;
    logic addr_phase;
    logic rd_take;
    logic wr_take;
    logic slot_hit;
    logic [31:0] slot_off;
    logic [2:0] slot_sel;
    logic [31:0] slot_rec;
    logic [31:0] new_rec;
    logic refused;
    logic stat_rd;
    logic count_clear;
    logic [`FFH_IRQ_W-1:0] irq_set;
    logic [`FFH_IRQ_W-1:0] irq_clr;
    logic [31:0] rd_value;

    // ****************************************
    // Fault flags
    // ****************************************
    // Each flag other than the spare bit tracks its own cause, so any mix may stand at once
    genvar gi;
    generate
        for (gi = 0; gi < `FFH_NUM_FLAGS; gi++) begin : g_flag
            if (gi == `FFH_BIT_SPARE) begin : g_spare
                // Spare position never reports anything
                assign flags_live[gi] = 1'b0; // R2
            end else begin : g_live
                // Set while the cause stands, gone with it
                assign flags_live[gi] = fault_cond[gi]; // R1 R14
            end
        end
    endgenerate

    // Named views of the class inputs that carry special meaning
    logic device_class_fault_flag;
    logic vendor_rotation_fault_flag;
    assign device_class_fault_flag = flags_live[`FFH_BIT_DEVICE_CLASS]; // R4
    assign vendor_rotation_fault_flag = flags_live[`FFH_BIT_VENDOR_ROT]; // R3

    // ****************************************
    // New history record
    // ****************************************
    // Class byte is the flag register as it stands when the error lands
    assign new_rec = {rec_number, st_r.flags, rec_code}; // R12 R13

    // ****************************************
    // Bus address phase
    // ****************************************
    // A transfer is taken when selected, NONSEQ or SEQ (htrans[1] set) and the bus is ready
    assign addr_phase = hsel && htrans[1] && hready;
    assign rd_take = addr_phase && !hwrite;
    assign wr_take = addr_phase && hwrite;

    // Slot decode: eight aligned words from the first slot address
    assign slot_off = haddr - `FFH_ADDR_SLOT1;
    assign slot_hit = (haddr >= `FFH_ADDR_SLOT1) && (haddr <= `FFH_ADDR_SLOT8)
        && (haddr[1:0] == 2'b00);
    assign slot_sel = slot_off[4:2];

    // An empty history answers any slot read with the abort code
    assign refused = rd_take && slot_hit && (st_r.count == `FFH_COUNT_RESET); // R10

    // Reading the status register clears it
    assign stat_rd = rd_take && (haddr == `FFH_ADDR_IRQ_STAT);

    // ****************************************
    // Read data selection
    // ****************************************
    // Unmapped and reserved locations read as zero
    always_comb begin
        rd_value = 32'h0000_0000;
        if (haddr == `FFH_ADDR_FLAGS) begin
            rd_value = {24'h00_0000, st_r.flags};
        end else if (haddr == `FFH_ADDR_COUNT) begin
            rd_value = {24'h00_0000, st_r.count}; // R9
        end else if (slot_hit) begin
            if (st_r.count == `FFH_COUNT_RESET) begin
                rd_value = `FFH_ABORT_NO_DATA; // R10
            end else begin
                rd_value = slot_rec;
            end
        end else if (haddr == `FFH_ADDR_IRQ_STAT) begin
            rd_value = {29'h0000_0000, st_r.irq_stat};
        end else if (haddr == `FFH_ADDR_IRQ_MASK) begin
            rd_value = {29'h0000_0000, st_r.irq_mask};
        end else begin
            rd_value = 32'h0000_0000;
        end
    end

    // ****************************************
    // Data phase writes
    // ****************************************
    // Only a zero written to the count is accepted; it empties the history
    assign count_clear = (st_r.phase == FFH_ACC_WRITE)
        && (st_r.wr_addr == `FFH_ADDR_COUNT)
        && (hwdata[7:0] == 8'h00); // R11

    // ****************************************
    // Interrupt events
    // ****************************************
    always_comb begin
        irq_set = '0;
        irq_set[`FFH_IRQ_NEW_REC] = rec_valid;
        irq_set[`FFH_IRQ_REFUSED] = refused;
        irq_set[`FFH_IRQ_FLAG_CHG] = (flags_live != st_r.flags);
        irq_clr = stat_rd ? st_r.irq_stat : '0;
    end

    // ****************************************
    // History stack
    // ****************************************
    ffh_history u_history (
        .hclk(hclk),
        .hresetn(hresetn),
        .push(rec_valid),
        .push_rec(new_rec),
        .clear(count_clear),
        .rd_sel(slot_sel),
        .rd_rec(slot_rec)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_nxt = st_r;

        // Flags follow the live causes every cycle
        st_nxt.flags = flags_live; // R1
        st_nxt.flags[`FFH_BIT_DEVICE_CLASS] = device_class_fault_flag; // R4
        st_nxt.flags[`FFH_BIT_VENDOR_ROT] = vendor_rotation_fault_flag; // R3

        // Count restarts on a zero write, counts each record, saturates
        if (count_clear) begin
            st_nxt.count = `FFH_COUNT_RESET; // R11
        end
        if (rec_valid) begin
            if (count_clear) begin
                st_nxt.count = 8'h01;
            end else if (st_r.count != `FFH_COUNT_MAX) begin
                st_nxt.count = st_r.count + 8'h01; // R9
            end
        end

        // Sticky status: a new event wins over the read clear
        st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | irq_set;

        // Mask register write in the data phase
        if ((st_r.phase == FFH_ACC_WRITE) && (st_r.wr_addr == `FFH_ADDR_IRQ_MASK)) begin
            st_nxt.irq_mask = hwdata[`FFH_IRQ_W-1:0];
        end

        // Track the phase of the bus transfer
        if (wr_take) begin
            st_nxt.phase = FFH_ACC_WRITE;
            st_nxt.wr_addr = haddr;
        end else if (rd_take) begin
            st_nxt.phase = FFH_ACC_READ;
            st_nxt.rdata = rd_value;
        end else if (hready) begin
            st_nxt.phase = FFH_ACC_NONE;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r.flags <= `FFH_FLAGS_RESET;
            st_r.count <= `FFH_COUNT_RESET;
            st_r.irq_stat <= '0;
            st_r.irq_mask <= '0;
            st_r.phase <= FFH_ACC_NONE;
            st_r.wr_addr <= 32'h0000_0000;
            st_r.rdata <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Zero wait states and an OKAY answer on every transfer
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_r.rdata;
    assign fault_flags = st_r.flags; // R2
    assign error_history_count = st_r.count;
    assign history_empty = (st_r.count == `FFH_COUNT_RESET);
    assign irq = |(st_r.irq_stat & st_r.irq_mask);

endmodule

// ===== test/ffh_ahb_master.sv
// Register bus master standing in for the fieldbus master
`include "ffh_regs.svh"
module ffh_ahb_master (
    input wire logic hclk, // Bus clock
    input wire logic hready, // Bus ready
    input wire logic [31:0] hrdata, // Read data
    output logic hsel, // Slave select
    output logic [31:0] haddr, // Byte address
    output logic [1:0] htrans, // Transfer type
    output logic hwrite, // High for write
    output logic [2:0] hsize, // Always a word
    output logic [31:0] hwdata // Write data
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
    end

    // One single word transfer; released haddr, hwrite and hwdata show the inverse of their last value, htrans goes idle
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q, output bit to);
        int n;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        hsel <= 1'b0;
        htrans <= 2'b00;
        haddr <= ~a;
        hwrite <= ~w;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        q = hrdata;
        hwdata <= ~d;
        to = (n >= 64);
    endtask
endmodule

// ===== test/ffh_top_properties.sv
// Port level checks of the fault flag register and history
`include "ffh_regs.svh"
module ffh_top_chk
    import ffh_pkg::*;
(
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset, active low
    input wire logic hsel, // Select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Ready in
    input wire logic [31:0] hrdata, // Read data
    input wire logic [7:0] fault_cond, // Conditions
    input wire logic rec_valid, // Record strobe
    input wire logic [7:0] fault_flags, // Flags
    input wire logic [7:0] error_history_count, // Count
    input wire logic history_empty // Empty
);
    logic taken;
    logic wr_cnt_ph;
    logic rd_abort_ph;

    // Data phases of a count write and of a slot read on an empty history
    assign taken = hsel && htrans[1] && hready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_cnt_ph <= 1'b0;
            rd_abort_ph <= 1'b0;
        end else begin
            wr_cnt_ph <= taken && hwrite && haddr == `FFH_ADDR_COUNT;
            rd_abort_ph <= taken && !hwrite && history_empty
                && haddr >= `FFH_ADDR_SLOT1 && haddr <= `FFH_ADDR_SLOT8;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_zero_wr;
        wr_cnt_ph && hwdata[7:0] == 8'h00;
    endsequence

    a_flags_follow: assert property (
        $past(hresetn) |-> fault_flags == ($past(fault_cond) & 8'hbf))
        else $error("flags do not follow conditions");
    a_spare_zero: assert property (
        fault_flags[6] == 1'b0) else $error("spare flag set");
    a_rotation_flag: assert property (
        $past(hresetn) && $past(fault_cond[7]) |-> fault_flags[7])
        else $error("rotation flag missing");
    a_profile_flag: assert property (
        $past(hresetn) && $past(fault_cond[5]) |-> fault_flags[5])
        else $error("profile flag missing");
    a_count_step: assert property (
        rec_valid && !(wr_cnt_ph && hwdata[7:0] == 8'h00) && error_history_count != 8'hff
        |=> error_history_count == $past(error_history_count) + 8'h01)
        else $error("count did not step");
    a_count_sat: assert property (
        rec_valid && !wr_cnt_ph && error_history_count == 8'hff
        |=> error_history_count == 8'hff) else $error("count wrapped");
    a_count_clear: assert property (
        s_zero_wr ##0 !rec_valid |=> error_history_count == 8'h00 && history_empty)
        else $error("count not restarted");
    a_abort_data: assert property (
        rd_abort_ph |-> hrdata == `FFH_ABORT_NO_DATA) else $error("empty read not refused");
endmodule

bind ffh_top ffh_top_chk ffh_top_chk_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .fault_cond, .rec_valid, .fault_flags,
    .error_history_count, .history_empty);

// ===== test/ffh_top_test.sv
// Self-checking bench of the fault flag register and error history
`include "ffh_regs.svh"
module ffh_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, rec_valid, history_empty, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0] fault_cond, rec_number, fault_flags, error_history_count, prev;
    logic [15:0] rec_code;
    logic [31:0] hist [8];
    int n_fail = 0;
    int samples_checked = 0;

    // 10 MHz clock
    always #50 hclk = ~hclk;

    ffh_top ffh_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .fault_cond,
        .rec_valid, .rec_number, .rec_code, .fault_flags, .error_history_count,
        .history_empty, .irq);
    ffh_ahb_master bus (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata);

    // Expected flag register word
    function automatic logic [31:0] f_flags(logic [7:0] c);
        return {24'h0, c & 8'hbf};
    endfunction

    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Bus transfer, a hang ends the run
    task automatic xf(logic w, logic [31:0] a, logic [31:0] d, output logic [31:0] q);
        bit to;
        bus.xfer(w, a, d, q, to);
        if (to) begin
            chk("bus wait", 32'h0, 32'h1);
            end_sim;
        end
    endtask

    task automatic rdc(logic [31:0] a, logic [31:0] e, string nm);
        logic [31:0] q;
        xf(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    task automatic wr(logic [31:0] a, logic [31:0] d);
        logic [31:0] q;
        xf(1'b1, a, d, q);
    endtask

    initial begin
        fault_cond = 8'h00;
        rec_valid = 1'b0;
        rec_number = 8'h00;
        rec_code = 16'h0;
        void'($urandom(32'hb7ba));
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(`FFH_ADDR_FLAGS, 32'h0, "flags reset");
        rdc(`FFH_ADDR_COUNT, 32'h0, "count reset");
        rdc(32'h0000_4000, 32'h0, "unmapped");
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("history empty", 32'h1, {31'h0, history_empty});
        for (int i = 0; i < 8; i++) begin
            rdc(`FFH_ADDR_SLOT1 + 32'(4 * i), `FFH_ABORT_NO_DATA, "empty slot");
        end
        // Each class alone, then a random mix; writes to flags are ignored
        for (int i = 0; i < 10; i++) begin
            fault_cond <= (i < 8) ? 8'h01 << i : 8'($urandom);
            repeat (2) @(posedge hclk);
            wr(`FFH_ADDR_FLAGS, 32'hff);
            rdc(`FFH_ADDR_FLAGS, f_flags(fault_cond), "flags");
        end
        rdc(`FFH_ADDR_IRQ_STAT, 32'h6, "irq status");
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`FFH_ADDR_IRQ_MASK, 32'h1);
        rdc(`FFH_ADDR_IRQ_MASK, 32'h1, "irq mask");
        // Back-to-back records with changing conditions, beyond saturation
        prev = fault_cond;
        for (int i = 0; i < 300; i++) begin
            rec_valid <= 1'b1;
            rec_number <= 8'($urandom);
            rec_code <= 16'($urandom);
            fault_cond <= 8'($urandom);
            @(posedge hclk);
            for (int k = 7; k > 0; k--) hist[k] = hist[k - 1];
            hist[0] = {rec_number, prev & 8'hbf, rec_code};
            prev = fault_cond;
        end
        rec_valid <= 1'b0;
        @(posedge hclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        rdc(`FFH_ADDR_COUNT, 32'hff, "count");
        chk("history held", 32'h0, {31'h0, history_empty});
        chk("hresp busy", 32'h0, {31'h0, hresp});
        for (int i = 0; i < 8; i++) begin
            rdc(`FFH_ADDR_SLOT1 + 32'(4 * i), hist[i], "slot");
        end
        rdc(`FFH_ADDR_IRQ_STAT, 32'h5, "irq status");
        @(posedge hclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Restart of the count
        wr(`FFH_ADDR_COUNT, 32'h5);
        rdc(`FFH_ADDR_COUNT, 32'hff, "count kept");
        wr(`FFH_ADDR_COUNT, 32'h0);
        rdc(`FFH_ADDR_COUNT, 32'h0, "count cleared");
        rdc(`FFH_ADDR_SLOT8, `FFH_ABORT_NO_DATA, "cleared slot");
        rec_valid <= 1'b1;
        rec_number <= 8'h05;
        rec_code <= 16'h1000;
        @(posedge hclk);
        rec_valid <= 1'b0;
        rdc(`FFH_ADDR_SLOT1, {8'h05, prev & 8'hbf, 16'h1000}, "first slot");
        rdc(`FFH_ADDR_COUNT, 32'h1, "count one");
        end_sim;
    end
endmodule
